// [logic/ist_ctrl_regs.sv]
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module ist_ctrl_regs
   import ist_pkg::*;
#(
   parameter int N_FAST = NUM_FAST
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // State from the interrupt core
   input wire logic [UPPER_IRQS-1:0] enable_state_bits,
   input wire logic [LOWER_PEND_W+UPPER_IRQS-1:0] pending_state_bits,
   input wire logic cand_valid,
   input wire logic [7:0] cand_priority,
   input wire logic nmi_taken,
   input wire logic exc_taken,
   // Controls to the interrupt core
   output logic cand_service,
   output logic nmi_pending,
   output logic exc_pending,
   output logic nesting_off_bit,
   output logic hw_stack_off_bit,
   output logic whole_system_reset_bit,
   output logic controller_reset_bit,
   output logic [N_FAST*32-1:0] fast_vectors,
   output logic [N_FAST*FAST_ID_W-1:0] fast_irq_numbers,
   // Interrupt line
   output logic irq
);
   // ==========================================================
   // Bus decode
   logic wr_acc;
   logic rd_setup;
   logic mapped;
   logic [KEY_W-1:0] write_unlock_field;
   logic cfg_wr;
   logic key_cfg_ok;
   logic key_pend_ok;
   logic key_rst_ok;
   logic key_reject;
   logic [THR_W-1:0] threshold;
   logic [BASE_W-1:0] fast_vector_high_nibble;
   logic [EV_W-1:0] irq_status;
   logic [EV_W-1:0] irq_mask;
   logic [EV_W-1:0] ev_set;
   logic [31:0] next_prdata;
   logic [31:0] slot_rd [N_FAST];
   logic [N_FAST-1:0] slot_hit;
   logic ctrl_clear;

   // Zero-wait slave; read data are latched in the setup cycle
   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign write_unlock_field = pwdata[KEY_LSB +: KEY_W];
   assign cfg_wr = wr_acc && (paddr == ADDR_CONFIG);
   assign ctrl_clear = controller_reset_bit;

   // Known offsets answer OK, anything else raises pslverr
   always_comb
   begin
      mapped = 1'b0;
      if (paddr == ADDR_UPPER_EN)
         mapped = 1'b1;
      else if (paddr == ADDR_LOWER_PEND)
         mapped = 1'b1;
      else if (paddr == ADDR_UPPER_PEND)
         mapped = 1'b1;
      else if (paddr == ADDR_THRESHOLD)
         mapped = 1'b1;
      else if (paddr == ADDR_FAST_BASE)
         mapped = 1'b1;
      else if (paddr == ADDR_CONFIG)
         mapped = 1'b1;
      else if (paddr == ADDR_IRQ_STATUS)
         mapped = 1'b1;
      else if (paddr == ADDR_IRQ_MASK)
         mapped = 1'b1;
      else if (|slot_hit)
         mapped = 1'b1;
   end

   assign pslverr = psel && penable && !mapped;

   // ==========================================================
   // Key checks
   assign key_cfg_ok = (write_unlock_field == CONFIG_UNLOCK_VALUE);
   assign key_pend_ok = (write_unlock_field == PEND_UNLOCK_VALUE);
   assign key_rst_ok = (write_unlock_field == RESET_UNLOCK_VALUE);
   // A protected 1 (or a nest/stack change) without its key is flagged
   assign key_reject = cfg_wr && (
      (pwdata[CFG_SYS_RESET] && !key_rst_ok) ||
      ((|pwdata[CFG_EXC_CLR:CFG_NMI_SET]) && !key_pend_ok) ||
      (((pwdata[CFG_NEST_OFF] != nesting_off_bit) ||
        (pwdata[CFG_STACK_OFF] != hw_stack_off_bit)) && !key_cfg_ok));

   // ==========================================================
   // Threshold register, high nibble only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         threshold <= THR_RESET;
      else if (ctrl_clear)
         threshold <= THR_RESET;
      else if (wr_acc && paddr == ADDR_THRESHOLD)
         threshold <= pwdata[THR_LSB +: THR_W];
   end

   // Blocked candidates are not cleared here, they simply stay pending
   assign cand_service = cand_valid &&
      ((threshold == THR_RESET) || (cand_priority >= {threshold, 4'h0}));

   // ==========================================================
   // Fast vector base and offset slots
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fast_vector_high_nibble <= BASE_RESET;
      else if (ctrl_clear)
         fast_vector_high_nibble <= BASE_RESET;
      else if (wr_acc && paddr == ADDR_FAST_BASE)
         fast_vector_high_nibble <= pwdata[BASE_LSB +: BASE_W];
   end

   for (genvar i = 0; i < N_FAST; i++)
   begin : g_slot
      assign slot_hit[i] = (paddr == ADDR_FAST_OFF0 + 12'(4 * i));
      ist_fast_slot u_slot (
         .pclk(pclk),
         .presetn(presetn),
         .ctrl_clear(ctrl_clear),
         .wr_en(wr_acc && slot_hit[i]),
         .wdata(pwdata),
         .base(fast_vector_high_nibble),
         .fast_irq_number(fast_irq_numbers[i*FAST_ID_W +: FAST_ID_W]),
         .fast_offset_field(),
         .rd_view(slot_rd[i]),
         .vector(fast_vectors[i*32 +: 32])
      );
   end

   // ==========================================================
   // Config register: keyed nesting and stack bits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         nesting_off_bit <= 1'b0;
         hw_stack_off_bit <= 1'b0;
      end
      else if (ctrl_clear)
      begin
         nesting_off_bit <= 1'b0;
         hw_stack_off_bit <= 1'b0;
      end
      else if (cfg_wr && key_cfg_ok)
      begin
         nesting_off_bit <= pwdata[CFG_NEST_OFF];
         hw_stack_off_bit <= pwdata[CFG_STACK_OFF];
      end
   end

   // Self-clearing reset pulses, one cycle wide
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         whole_system_reset_bit <= 1'b0;
         controller_reset_bit <= 1'b0;
      end
      else
      begin
         whole_system_reset_bit <= cfg_wr && key_rst_ok && pwdata[CFG_SYS_RESET];
         controller_reset_bit <= cfg_wr && pwdata[CFG_CTRL_RESET];
      end
   end

   // NMI and exception pend; a set beats a clear or a take in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         nmi_pending <= 1'b0;
         exc_pending <= 1'b0;
      end
      else if (ctrl_clear)
      begin
         nmi_pending <= 1'b0;
         exc_pending <= 1'b0;
      end
      else
      begin
         if (cfg_wr && key_pend_ok && pwdata[CFG_NMI_SET])
            nmi_pending <= 1'b1;
         else if ((cfg_wr && key_pend_ok && pwdata[CFG_NMI_CLR]) || nmi_taken)
            nmi_pending <= 1'b0;
         if (cfg_wr && key_pend_ok && pwdata[CFG_EXC_SET])
            exc_pending <= 1'b1;
         else if ((cfg_wr && key_pend_ok && pwdata[CFG_EXC_CLR]) || exc_taken)
            exc_pending <= 1'b0;
      end
   end

   // ==========================================================
   // Sticky events, write one to clear, set wins
   assign ev_set[EV_KEY_REJECT] = key_reject;
   assign ev_set[EV_CTRL_RESET] = controller_reset_bit;
   assign ev_set[EV_THR_BLOCK] = cand_valid && !cand_service;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_status <= '0;
      else if (wr_acc && paddr == ADDR_IRQ_STATUS)
         irq_status <= (irq_status & ~pwdata[EV_W-1:0]) | ev_set;
      else
         irq_status <= irq_status | ev_set;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_mask <= '0;
      else if (wr_acc && paddr == ADDR_IRQ_MASK)
         irq_mask <= pwdata[EV_W-1:0];
   end

   assign irq = |(irq_status & irq_mask);

   // ==========================================================
   // Read mux, registered at the setup cycle
   always_comb
   begin
      next_prdata = 32'h0000_0000;
      if (paddr == ADDR_UPPER_EN)
         next_prdata = {28'h000_0000, enable_state_bits};
      else if (paddr == ADDR_LOWER_PEND)
         next_prdata = {pending_state_bits[LOWER_PEND_W-1:0], 12'h000};
      else if (paddr == ADDR_UPPER_PEND)
         next_prdata = {28'h000_0000,
            pending_state_bits[LOWER_PEND_W +: UPPER_IRQS]};
      else if (paddr == ADDR_THRESHOLD)
         next_prdata = {24'h00_0000, threshold, 4'h0};
      else if (paddr == ADDR_FAST_BASE)
         next_prdata = {fast_vector_high_nibble, 28'h000_0000};
      else if (paddr == ADDR_CONFIG)
         next_prdata = {16'h0000, 14'h0000, nesting_off_bit, hw_stack_off_bit};
      else if (paddr == ADDR_IRQ_STATUS)
         next_prdata = {29'h0000_0000, irq_status};
      else if (paddr == ADDR_IRQ_MASK)
         next_prdata = {29'h0000_0000, irq_mask};
      else
      begin
         for (int k = 0; k < N_FAST; k++)
         begin
            if (slot_hit[k])
               next_prdata = slot_rd[k];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
         prdata <= next_prdata;
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_read_setup(logic [11:0] a);
      psel && !penable && !pwrite && paddr == a;
   endsequence

   sequence s_cfg_write(logic [15:0] k, int b);
      cfg_wr && write_unlock_field == k && pwdata[b];
   endsequence

   AST_UPPER_EN_READ: assert property (
      s_read_setup(ADDR_UPPER_EN) |=> prdata == {28'h000_0000, $past(enable_state_bits)})
      else $error("upper enable read mismatch");

   AST_LOWER_PEND_READ: assert property (
      s_read_setup(ADDR_LOWER_PEND) |=> prdata[11:0] == 12'h000 &&
      prdata[31:12] == $past(pending_state_bits[LOWER_PEND_W-1:0]))
      else $error("lower pending read mismatch");

   AST_UPPER_PEND_READ: assert property (
      s_read_setup(ADDR_UPPER_PEND) |=> prdata[31:4] == 28'h000_0000 &&
      prdata[3:0] == $past(pending_state_bits[LOWER_PEND_W +: UPPER_IRQS]))
      else $error("upper pending read mismatch");

   AST_THR_BLOCK: assert property (
      cand_valid && threshold != 4'h0 && cand_priority < {threshold, 4'h0} |-> !cand_service)
      else $error("low priority interrupt serviced past threshold");

   AST_THR_ZERO: assert property (
      cand_valid && threshold == 4'h0 |-> cand_service)
      else $error("zero threshold masked an interrupt");

   AST_THR_NIBBLE: assert property (
      wr_acc && paddr == ADDR_THRESHOLD && !ctrl_clear ##2 s_read_setup(ADDR_THRESHOLD)
      |=> prdata == {24'h00_0000, $past(pwdata[7:4], 3), 4'h0})
      else $error("threshold readback wrong");

   AST_VECTOR_BASE: assert property (
      fast_vectors[31:28] == fast_vector_high_nibble && fast_vectors[27:20] == 8'h00)
      else $error("fast vector high bits wrong");

   AST_KEY_READS_ZERO: assert property (
      s_read_setup(ADDR_CONFIG) |=> prdata[31:2] == 30'h0000_0000)
      else $error("config key field not zero on read");

   AST_SYS_RESET_PULSE: assert property (
      s_cfg_write(RESET_UNLOCK_VALUE, CFG_SYS_RESET) ##1 !cfg_wr
      |-> whole_system_reset_bit ##1 !whole_system_reset_bit)
      else $error("system reset pulse wrong");

   AST_NMI_SET: assert property (
      s_cfg_write(PEND_UNLOCK_VALUE, CFG_NMI_SET) ##0 !ctrl_clear |=> nmi_pending)
      else $error("nmi not pended");

   AST_NEST_WRITE: assert property (
      cfg_wr && key_cfg_ok && !ctrl_clear |=> nesting_off_bit == $past(pwdata[CFG_NEST_OFF]))
      else $error("nesting bit not written");

   AST_BAD_KEY_HOLD: assert property (
      cfg_wr && !key_cfg_ok && !ctrl_clear |=> $stable(nesting_off_bit) && $stable(hw_stack_off_bit))
      else $error("protected bit changed without key");
endmodule // ist_ctrl_regs
`default_nettype wire

// [logic/ist_fast_slot.sv]
`timescale 1ns/1ps
`default_nettype none
module ist_fast_slot
   import ist_pkg::*;
#(
   parameter int ID_W = FAST_ID_W,
   parameter int OFF_W = FAST_OFF_W
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Controls
   input wire logic ctrl_clear,
   input wire logic wr_en,
   input wire logic [31:0] wdata,
   input wire logic [BASE_W-1:0] base,
   // Results
   output logic [ID_W-1:0] fast_irq_number,
   output logic [OFF_W-1:0] fast_offset_field,
   output logic [31:0] rd_view,
   output logic [31:0] vector
);
   // ==========================================================
   // Offset register: the IRQ number and the low offset bits are stored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fast_irq_number <= FAST_ID_RESET;
         fast_offset_field <= FAST_OFF_RESET;
      end
      else if (ctrl_clear)
      begin
         fast_irq_number <= FAST_ID_RESET;
         fast_offset_field <= FAST_OFF_RESET;
      end
      else if (wr_en)
      begin
         fast_irq_number <= wdata[FAST_ID_LSB +: ID_W];
         fast_offset_field <= wdata[OFF_W-1:0];
      end
   end

   // Bits 23..20 are fixed zero, so the vector needs no masking
   assign rd_view = {fast_irq_number, 4'h0, fast_offset_field};
   assign vector = {base, 4'h0, 4'h0, fast_offset_field};
endmodule // ist_fast_slot
`default_nettype wire

// [logic/ist_pkg.sv]
`default_nettype none
package ist_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [11:0] ADDR_UPPER_EN = 12'h004;
   localparam logic [11:0] ADDR_LOWER_PEND = 12'h020;
   localparam logic [11:0] ADDR_UPPER_PEND = 12'h024;
   localparam logic [11:0] ADDR_THRESHOLD = 12'h040;
   localparam logic [11:0] ADDR_FAST_BASE = 12'h044;
   localparam logic [11:0] ADDR_CONFIG = 12'h048;
   localparam logic [11:0] ADDR_FAST_OFF0 = 12'h060;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h080;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h084;
   // ==========================================================
   // Field positions and widths
   localparam int NUM_FAST = 4;
   localparam int UPPER_IRQS = 4;
   localparam int LOWER_PEND_LSB = 12;
   localparam int LOWER_PEND_W = 20;
   localparam int THR_LSB = 4;
   localparam int THR_W = 4;
   localparam int BASE_LSB = 28;
   localparam int BASE_W = 4;
   localparam int FAST_ID_LSB = 24;
   localparam int FAST_ID_W = 8;
   localparam int FAST_OFF_W = 20;
   localparam int KEY_LSB = 16;
   localparam int KEY_W = 16;
   localparam int CFG_SYS_RESET = 7;
   localparam int CFG_CTRL_RESET = 6;
   localparam int CFG_EXC_CLR = 5;
   localparam int CFG_EXC_SET = 4;
   localparam int CFG_NMI_CLR = 3;
   localparam int CFG_NMI_SET = 2;
   localparam int CFG_NEST_OFF = 1;
   localparam int CFG_STACK_OFF = 0;
   // ==========================================================
   // Unlock values
   localparam logic [15:0] CONFIG_UNLOCK_VALUE = 16'hFA05;
   localparam logic [15:0] PEND_UNLOCK_VALUE = 16'hBCAF;
   localparam logic [15:0] RESET_UNLOCK_VALUE = 16'hBEEF;
   // ==========================================================
   // Event bits of the interrupt status register
   localparam int EV_KEY_REJECT = 0;
   localparam int EV_CTRL_RESET = 1;
   localparam int EV_THR_BLOCK = 2;
   localparam int EV_W = 3;
   // ==========================================================
   // Reset values
   localparam logic [3:0] THR_RESET = 4'h0;
   localparam logic [3:0] BASE_RESET = 4'h0;
   localparam logic [7:0] FAST_ID_RESET = 8'h00;
   localparam logic [19:0] FAST_OFF_RESET = 20'h0_0000;
endpackage
`default_nettype wire

// [verif/ist_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ist_core_model
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pending flags seen by the core
   input wire logic nmi_pending,
   input wire logic exc_pending,
   // Bench controls: take or not, and how slowly
   input wire logic take_en,
   input wire logic [3:0] delay,
   // Acknowledges
   output logic nmi_taken,
   output logic exc_taken
);
   // ==========================================================
   // Taking logic
   logic [1:0] pend;
   logic [1:0] tk;
   logic [3:0] wt [2];
   assign pend = {exc_pending, nmi_pending};
   assign nmi_taken = tk[0];
   assign exc_taken = tk[1];
   // Pulse once after the wait; a cycle off after a take avoids a double take
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tk <= 2'b00;
         wt <= '{4'h0, 4'h0};
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            tk[i] <= take_en && pend[i] && !tk[i] && wt[i] >= delay;
            if (tk[i] || !pend[i])
               wt[i] <= 4'h0;
            else if (wt[i] < delay)
               wt[i] <= wt[i] + 4'h1;
         end
      end
   end
endmodule // ist_core_model
`default_nettype wire

// [verif/test_interrupt_status_threshold_config.sv]
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_status_threshold_config;
   import ist_pkg::*;
   // ==========================================================
   // Signals
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, r32;
   logic [3:0] en_bits, delay;
   logic [23:0] pend_bits;
   logic cand_valid, cand_service, nmi_taken, exc_taken, take_en;
   logic [7:0] cand_priority;
   logic nmi_pending, exc_pending, nest, stk, sys_rst, ctl_rst, irq;
   logic [127:0] vec;
   logic [31:0] ids;
   logic [31:0] slot [4];
   logic [11:0] rst_addr [4];
   int error_cnt, cmp_count, p, ns, nc;
   ist_ctrl_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .enable_state_bits(en_bits), .pending_state_bits(pend_bits),
      .cand_valid(cand_valid), .cand_priority(cand_priority), .nmi_taken(nmi_taken),
      .exc_taken(exc_taken), .cand_service(cand_service), .nmi_pending(nmi_pending),
      .exc_pending(exc_pending), .nesting_off_bit(nest), .hw_stack_off_bit(stk),
      .whole_system_reset_bit(sys_rst), .controller_reset_bit(ctl_rst),
      .fast_vectors(vec), .fast_irq_numbers(ids), .irq(irq));
   ist_core_model i_core (.pclk(pclk), .presetn(presetn), .nmi_pending(nmi_pending),
      .exc_pending(exc_pending), .take_en(take_en), .delay(delay),
      .nmi_taken(nmi_taken), .exc_taken(exc_taken));
   // ==========================================================
   // Shared tasks
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 64)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 64)
         error_cnt++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
      @(negedge pclk);
   endtask
   task automatic rc(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0000_0000);
      chk(what, rd, exp);
   endtask
   // Counts reset pulses in the cycles after a write
   task automatic pulses();
      ns = 0;
      nc = 0;
      repeat (4)
      begin
         if (sys_rst === 1'b1)
            ns++;
         if (ctl_rst === 1'b1)
            nc++;
         @(negedge pclk);
      end
   endtask
   function automatic logic pend_of(input int e);
      return (e == 0) ? nmi_pending : exc_pending;
   endfunction
   task automatic results();
      if (error_cnt == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ==========================================================
   // Clock and watchdog
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial
   begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      results();
   end
   // ==========================================================
   // Main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, cand_valid, take_en} = 6'b000000;
      {paddr, pwdata, en_bits, pend_bits, cand_priority, delay} = '0;
      error_cnt = 0;
      cmp_count = 0;
      void'($urandom(32'h69dbffd6));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values of threshold, base, config and the first slot
      rst_addr = '{ADDR_THRESHOLD, ADDR_FAST_BASE, ADDR_CONFIG, ADDR_FAST_OFF0};
      foreach (rst_addr[i])
         rc("reset", rst_addr[i], 32'h0000_0000);
      // Read-only state views ignore writes
      r32 = $urandom;
      en_bits <= r32[3:0];
      pend_bits <= r32[31:8];
      wr(ADDR_UPPER_EN, 32'hFFFF_FFFF);
      wr(ADDR_LOWER_PEND, 32'hFFFF_FFFF);
      rc("upper_en", ADDR_UPPER_EN, {28'h000_0000, r32[3:0]});
      rc("lower_pend", ADDR_LOWER_PEND, {r32[27:8], 12'h000});
      rc("upper_pend", ADDR_UPPER_PEND, {28'h000_0000, r32[31:28]});
      // Every threshold, priorities at and just under it
      for (int k = 0; k < 16; k++)
      begin
         r32 = $urandom;
         wr(ADDR_THRESHOLD, {r32[31:8], 4'(k), r32[3:0]});
         rc("threshold", ADDR_THRESHOLD, {24'h00_0000, 4'(k), 4'h0});
         for (int j = 0; j < 3; j++)
         begin
            p = (j == 0) ? k * 16 : (j == 1) ? k * 16 - 1 : $urandom_range(255);
            p = (p < 0) ? 0 : p;
            // Candidate changes only on a rising edge
            @(posedge pclk);
            cand_valid <= 1'b1;
            cand_priority <= 8'(p);
            @(negedge pclk);
            chk("service", {31'h0, cand_service}, {31'h0, (k == 0 || p >= k * 16)});
         end
      end
      @(posedge pclk);
      cand_valid <= 1'b0;
      // Fast vector base and slots
      r32 = $urandom;
      wr(ADDR_FAST_BASE, r32);
      rc("base", ADDR_FAST_BASE, {r32[31:28], 28'h000_0000});
      for (int i = 0; i < 4; i++)
      begin
         slot[i] = $urandom;
         wr(ADDR_FAST_OFF0 + 12'(4 * i), slot[i]);
         rc("slot", ADDR_FAST_OFF0 + 12'(4 * i), {slot[i][31:24], 4'h0, slot[i][19:0]});
         chk("vector", vec[i*32+:32], {r32[31:28], 8'h00, slot[i][19:0]});
         chk("number", {24'h0, ids[i*8+:8]}, {24'h0, slot[i][31:24]});
      end
      // Nesting and stack controls with the right and the wrong key
      wr(ADDR_IRQ_STATUS, 32'h0000_0007);
      wr(ADDR_IRQ_MASK, 32'h0000_0007);
      wr(ADDR_CONFIG, {CONFIG_UNLOCK_VALUE, 16'h0003});
      rc("config", ADDR_CONFIG, 32'h0000_0003);
      chk("nest_stack", {30'h0, nest, stk}, 32'h0000_0003);
      wr(ADDR_CONFIG, {PEND_UNLOCK_VALUE, 16'h0000});
      rc("config", ADDR_CONFIG, 32'h0000_0003);
      rc("status", ADDR_IRQ_STATUS, 32'h0000_0001);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(ADDR_IRQ_MASK, 32'h0000_0000);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      wr(ADDR_IRQ_STATUS, 32'h0000_0001);
      rc("status", ADDR_IRQ_STATUS, 32'h0000_0000);
      wr(ADDR_CONFIG, {CONFIG_UNLOCK_VALUE, 16'h0000});
      chk("nest_stack", {30'h0, nest, stk}, 32'h0000_0000);
      // Pend and clear of NMI (e=0) and exception (e=1)
      for (int e = 0; e < 2; e++)
      begin
         wr(ADDR_CONFIG, {RESET_UNLOCK_VALUE, 16'(4 << (2 * e))});
         chk("pend", {31'h0, pend_of(e)}, 32'h0);
         wr(ADDR_CONFIG, {PEND_UNLOCK_VALUE, 16'(4 << (2 * e))});
         chk("pend", {31'h0, pend_of(e)}, 32'h1);
         wr(ADDR_CONFIG, {PEND_UNLOCK_VALUE, 16'h0000});
         chk("pend", {31'h0, pend_of(e)}, 32'h1);
         wr(ADDR_CONFIG, {PEND_UNLOCK_VALUE, 16'(8 << (2 * e))});
         chk("pend", {31'h0, pend_of(e)}, 32'h0);
         // Core takes it, promptly and then slowly
         for (int s = 0; s < 2; s++)
         begin
            @(posedge pclk);
            delay <= 4'(5 * s);
            take_en <= 1'b1;
            wr(ADDR_CONFIG, {PEND_UNLOCK_VALUE, 16'(4 << (2 * e))});
            repeat (12) @(negedge pclk);
            chk("taken", {31'h0, pend_of(e)}, 32'h0);
            @(posedge pclk);
            take_en <= 1'b0;
         end
      end
      // System reset: wrong key, no bit, then the real one
      wr(ADDR_CONFIG, {CONFIG_UNLOCK_VALUE, 16'h0080});
      pulses();
      chk("sys_rst", ns, 0);
      wr(ADDR_CONFIG, {RESET_UNLOCK_VALUE, 16'h0000});
      pulses();
      chk("sys_rst", ns, 0);
      wr(ADDR_CONFIG, {RESET_UNLOCK_VALUE, 16'h0080});
      pulses();
      chk("sys_rst", ns, 1);
      // Controller reset clears the block's own settings except the event mask and the event status
      wr(ADDR_CONFIG, {CONFIG_UNLOCK_VALUE, 16'h0003});
      wr(ADDR_CONFIG, 32'h0000_0040);
      pulses();
      chk("ctl_rst", nc, 1);
      rc("threshold", ADDR_THRESHOLD, 32'h0000_0000);
      rc("base", ADDR_FAST_BASE, 32'h0000_0000);
      rc("config", ADDR_CONFIG, 32'h0000_0000);
      chk("vector", vec[31:0], 32'h0000_0000);
      apb(ADDR_IRQ_STATUS, 1'b0, 32'h0);
      chk("status", rd & 32'h2, 32'h0000_0002);
      // Threshold blocking raises its event
      wr(ADDR_THRESHOLD, 32'h0000_0080);
      @(posedge pclk);
      cand_valid <= 1'b1;
      cand_priority <= 8'h10;
      @(negedge pclk);
      chk("service", {31'h0, cand_service}, 32'h0);
      wr(ADDR_IRQ_MASK, 32'h0000_0004);
      apb(ADDR_IRQ_STATUS, 1'b0, 32'h0);
      chk("status", rd & 32'h4, 32'h0000_0004);
      chk("irq", {31'h0, irq}, 32'h1);
      // Unmapped address is refused
      apb(12'h0FC, 1'b1, 32'hFFFF_FFFF);
      chk("slverr", {31'h0, err}, 32'h1);
      apb(12'h0FC, 1'b0, 32'h0);
      chk("slverr", {31'h0, err}, 32'h1);
      chk("unmapped", rd, 32'h0000_0000);
      results();
   end
endmodule // test_interrupt_status_threshold_config
`default_nettype wire
